// ---- src/sar_adc_conversion_control.sv ----
// Notes on behaviour
// R1: Any write to the low result register starts a conversion; data ignored.
// R2: Such a write during a conversion aborts it and restarts at once.
// R3: Phases run sample, conversion with calibration, then result write.
// R4: Total conversion time is sample plus conversion phase plus the one-cycle write phase.
// R5: Every result has ten bits.
// R6: One of fifteen channels is converted; pins stay readable as digital inputs.
// R7: Software selects single or continuous conversion mode.
// R8: Start comes from the software write or the external start input.
// R9: Every completed conversion raises an interrupt request, unless a new start arrives during its write phase.
// R10: Conversion is a successive-approximation search over the capacitor array.
// R11: Offset calibration runs hidden inside the conversion phase.
// R12: Conversion and sample clocks are divided down from the input clock.
// R13: Software keeps the conversion clock at or under 2 MHz.
// R14: Each prescaler setting picks a fixed pair of ratios, one for each derived clock.
// R15: The interrupt flag sets once the new result is readable.
// R16: Continuous mode restarts right after the one-cycle notify phase that follows the write phase, without a trigger.
`timescale 1ns/1ns
`include "adc_ctrl_map.svh"
module sar_adc_conversion_control
  import adc_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic     sys_clk,
  input  wire logic     reset_n,
  // Software side.
  input  wire adc_cfg_t cfg,
  input  wire logic     result_low_write,
  input  wire logic     irq_clear,
  output code_t         result_data_q,
  output logic [3:0]    result_channel_q,
  output logic          busy_q,
  output logic          irq_q,
  output logic [14:0]   digital_in_q,
  // Pins and analog front end.
  input  wire logic     ext_start,
  input  wire logic     cmp_in,
  input  wire logic [14:0] analog_pins,
  output analog_drive_t drive_q
);
  // Pin synchronisers: stage 1 feeds stage 2 only; a change counts when 2 and 3 agree.
  logic [16:0] sync1_q, sync2_q, sync3_q, filt_q, filt_d;
  logic        ext_rise;

  always_comb
  begin
    filt_d = filt_q;
    for (int i = 0; i < 17; i++)
    begin
      if (sync2_q[i] == sync3_q[i])
      begin
        filt_d[i] = sync3_q[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q  <= '0;
    end
    else
    begin
      sync1_q <= {cmp_in, ext_start, analog_pins};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= filt_d;
    end
  end

  // R8: external trigger edge
  assign ext_rise = filt_d[15] & ~filt_q[15];

  // R14: one ratio pair per setting
  function automatic logic [5:0] div_ratio(input logic [1:0] presc, input logic smp);
    case (presc)
      2'h0: div_ratio = smp ? `ADC_SMP_DIV_0 : `ADC_CONV_DIV_0;
      2'h1: div_ratio = smp ? `ADC_SMP_DIV_1 : `ADC_CONV_DIV_1;
      2'h2: div_ratio = smp ? `ADC_SMP_DIV_2 : `ADC_CONV_DIV_2;
      default: div_ratio = smp ? `ADC_SMP_DIV_3 : `ADC_CONV_DIV_3;
    endcase
  endfunction

  // Control state.
  adc_state_t  state_q, state_d;
  logic [5:0]  div_q, div_d;
  logic [3:0]  step_q, step_d;
  code_t       sar_q, sar_d, final_code;
  logic        offset_q, offset_d;
  logic [3:0]  chan_q, chan_d;
  logic        start, tick, busy_d, irq_d;
  logic [1:0]  presc_q, presc_d;
  analog_drive_t drive_d;

  // R1: dummy write starts a conversion
  assign start = result_low_write | (cfg.ext_trig_en & ext_rise);
  // R12: one-cycle enable from the divider
  assign tick = (div_q == 6'h00);
  // R11: subtract the calibrated offset, saturating at zero
  assign final_code = (offset_q && sar_q != '0) ? sar_q - `ADC_ONE_CODE : sar_q;

  always_comb
  begin
    state_d  = state_q;
    div_d    = tick ? div_ratio(presc_q, state_q == ST_SAMPLE) - 6'h01 : div_q - 6'h01;
    step_d   = step_q;
    sar_d    = sar_q;
    offset_d = offset_q;
    chan_d   = chan_q;
    presc_d  = presc_q;
    case (state_q)
      ST_IDLE:
      begin
        div_d = '0;
      end
      ST_SAMPLE:
      begin
        if (tick)
        begin
          step_d = step_q - 4'h1;
          if (step_q == 4'h1)
          begin
            state_d = ST_CAL;
            step_d  = `ADC_CAL_TICKS;
            div_d   = div_ratio(presc_q, 1'b0) - 6'h01;
          end
        end
      end
      ST_CAL:
      begin
        if (tick)
        begin
          step_d = step_q - 4'h1;
          if (step_q == 4'h1)
          begin
            offset_d = filt_q[16];
            state_d  = ST_CONVERT;
            step_d   = `ADC_MSB_INDEX;
            // R5: ten-bit trial word
            sar_d    = code_t'(1) << `ADC_MSB_INDEX;
          end
        end
      end
      ST_CONVERT:
      begin
        // R10: keep or drop the trial bit, then try the next lower one
        if (tick)
        begin
          sar_d[step_q] = filt_q[16];
          if (step_q == 4'h0)
          begin
            state_d = ST_WRITE;
          end
          else
          begin
            sar_d[step_q - 4'h1] = 1'b1;
            step_d = step_q - 4'h1;
          end
        end
      end
      ST_WRITE:
      begin
        // R4: untimed result write
        state_d = ST_NOTIFY;
      end
      ST_NOTIFY:
      begin
        // R7 R16: restart or stop
        state_d = cfg.continuous ? ST_SAMPLE : ST_IDLE;
        step_d  = `ADC_SAMPLE_TICKS;
        div_d   = div_ratio(presc_q, 1'b1) - 6'h01;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    // R2: a new start overrides any phase
    if (start)
    begin
      state_d = ST_SAMPLE;
      step_d  = `ADC_SAMPLE_TICKS;
      presc_d = cfg.prescaler;
      chan_d  = cfg.channel;
      div_d   = div_ratio(cfg.prescaler, 1'b1) - 6'h01;
      sar_d   = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q  <= ST_IDLE;
      div_q    <= '0;
      step_q   <= '0;
      sar_q    <= '0;
      offset_q <= 1'b0;
      chan_q   <= '0;
      presc_q  <= '0;
    end
    else
    begin
      state_q  <= state_d;
      div_q    <= div_d;
      step_q   <= step_d;
      sar_q    <= sar_d;
      offset_q <= offset_d;
      chan_q   <= chan_d;
      presc_q  <= presc_d;
    end
  end

  // Outputs to the front end and software.
  always_comb
  begin
    drive_d.sample    = (state_d == ST_SAMPLE);
    drive_d.calibrate = (state_d == ST_CAL);
    drive_d.mux_sel   = chan_d;
    drive_d.dac_code  = (state_d == ST_CONVERT) ? sar_d : '0;
    busy_d            = (state_d == ST_SAMPLE) || (state_d == ST_CAL) ||
                        (state_d == ST_CONVERT) || (state_d == ST_WRITE);
    // R9 R15: set with readable result
    irq_d = (state_q == ST_NOTIFY) | (irq_q & ~irq_clear);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drive_q          <= '0;
      busy_q           <= 1'b0;
      irq_q            <= 1'b0;
      digital_in_q     <= '0;
      result_channel_q <= '0;
    end
    else
    begin
      drive_q      <= drive_d;
      busy_q       <= busy_d;
      irq_q        <= irq_d;
      // R6: pins stay readable as digital inputs
      digital_in_q <= filt_q[14:0];
      if (state_q == ST_WRITE)
      begin
        result_channel_q <= chan_q;
      end
    end
  end

  // R3: result written in the write phase, readable on the read port two cycles later
  adc_result_store u_store (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .wr_en     (state_q == ST_WRITE),
    .wr_addr   (chan_q),
    .wr_data   (final_code),
    .rd_addr   (cfg.channel),
    .rd_data_q (result_data_q)
  );

  // Assertions.
  a_start_restarts: assert property (@(posedge sys_clk) disable iff (!reset_n) // R2
    start |=> state_q == ST_SAMPLE && step_q == `ADC_SAMPLE_TICKS)
    else $error("start did not restart the sample phase");
  a_phase_order: assert property (@(posedge sys_clk) disable iff (!reset_n) // R3
    state_q == ST_CONVERT && state_d != ST_CONVERT && !start |-> state_d == ST_WRITE)
    else $error("conversion phase left other than into write");
  a_cal_before_conv: assert property (@(posedge sys_clk) disable iff (!reset_n) // R11
    state_q == ST_CAL && $past(state_q) == ST_SAMPLE |-> step_q == `ADC_CAL_TICKS)
    else $error("calibration entered with wrong step count");
  a_irq_after_write: assert property (@(posedge sys_clk) disable iff (!reset_n) // R15
    state_q == ST_WRITE && !start |=> state_q == ST_NOTIFY ##1 irq_q)
    else $error("interrupt flag not set after write phase");
  a_irq_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n) // R9
    irq_q && !irq_clear |=> irq_q)
    else $error("interrupt flag dropped without clear");
  a_cont_restart: assert property (@(posedge sys_clk) disable iff (!reset_n) // R16
    state_q == ST_NOTIFY && cfg.continuous |=> state_q == ST_SAMPLE)
    else $error("continuous mode did not restart");
  a_single_stops: assert property (@(posedge sys_clk) disable iff (!reset_n) // R7
    state_q == ST_NOTIFY && !cfg.continuous && !start |=> state_q == ST_IDLE && !busy_q)
    else $error("single mode did not stop");
  a_tick_ratio: assert property (@(posedge sys_clk) disable iff (!reset_n) // R14
    state_q == ST_CONVERT && tick && !start |=> div_q == div_ratio(presc_q, 1'b0) - 6'h01)
    else $error("conversion clock reloaded with wrong ratio");
  a_conv_bits: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
    state_q == ST_CAL && state_d == ST_CONVERT |=> drive_q.dac_code == 10'h200)
    else $error("search did not begin at the top bit");
  a_ext_trigger: assert property (@(posedge sys_clk) disable iff (!reset_n) // R8
    ext_rise && cfg.ext_trig_en |=> state_q == ST_SAMPLE)
    else $error("external trigger ignored");
endmodule

// ---- src/adc_ctrl_map.svh ----
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

// System clock rate and the ceiling on the conversion clock, both in kHz.
`define ADC_SYS_CLK_KHZ      10000
`define ADC_CONV_CLK_MAX_KHZ 2000
// Least divider that keeps the conversion clock at or under its ceiling (rounded up).
`define ADC_CONV_DIV_MIN ((`ADC_SYS_CLK_KHZ + `ADC_CONV_CLK_MAX_KHZ - 1) / `ADC_CONV_CLK_MAX_KHZ)

// Divider ratios, one pair per prescaler setting.
`define ADC_CONV_DIV_0 6'h05
`define ADC_CONV_DIV_1 6'h0a
`define ADC_CONV_DIV_2 6'h14
`define ADC_CONV_DIV_3 6'h28
`define ADC_SMP_DIV_0  6'h0a
`define ADC_SMP_DIV_1  6'h14
`define ADC_SMP_DIV_2  6'h28
`define ADC_SMP_DIV_3  6'h3c

// Phase lengths: sample clocks, calibration conversion clocks, result bits.
`define ADC_SAMPLE_TICKS 4'h4
`define ADC_CAL_TICKS    4'h2
`define ADC_RES_BITS     10
`define ADC_MSB_INDEX    4'h9
`define ADC_CHANNELS     15
`define ADC_ONE_CODE     10'h001

`endif

// ---- src/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;
  `include "adc_ctrl_map.svh"

  typedef logic [`ADC_RES_BITS-1:0] code_t;

  typedef struct packed {
    logic       continuous;
    logic       ext_trig_en;
    logic [1:0] prescaler;
    logic [3:0] channel;
  } adc_cfg_t;

  typedef struct packed {
    logic       sample;
    logic       calibrate;
    logic [3:0] mux_sel;
    code_t      dac_code;
  } analog_drive_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CAL,
    ST_CONVERT,
    ST_WRITE,
    ST_NOTIFY
  } adc_state_t;
endpackage

// ---- src/adc_result_store.sv ----
`timescale 1ns/1ns
module adc_result_store
  import adc_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic  sys_clk,
  input  wire logic  reset_n,
  // Write port.
  input  wire logic  wr_en,
  input  wire logic  [3:0] wr_addr,
  input  wire code_t wr_data,
  // Read port.
  input  wire logic  [3:0] rd_addr,
  output code_t      rd_data_q
);
  code_t mem_q [16];
  code_t rd_data_d;

  always_comb
  begin
    rd_data_d = mem_q[rd_addr];
  end

  // Storage is not reset; the read register is, so the port reads zero until the first clock after reset, then unknown until the entry is written.
  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_data_q <= '0;
    end
    else
    begin
      rd_data_q <= rd_data_d;
    end
  end
endmodule

// ---- testbench/adc_front_model.sv ----
`timescale 1ns/1ns
module adc_front_model
  import adc_ctrl_pkg::*;
(
  // Clock.
  input  wire logic          sys_clk,
  // Controls from the converter.
  input  wire analog_drive_t drive_q,
  // Bench controls.
  input  wire code_t         level,
  input  wire logic          offset_on,
  // Comparator.
  output logic               cmp_in
);
  code_t       held_q = 10'h000;
  logic [10:0] seen;
  always_ff @(posedge sys_clk)
  begin
    if (drive_q.sample)
      held_q <= level;
  end
  assign seen = {1'b0, held_q} + {10'h000, offset_on};
  // array compare, offset error.
  // The offset shows only as a one-code shift, which calibration must take back out.
  always_comb
  begin
    if (drive_q.calibrate)
      cmp_in = offset_on;
    else
      cmp_in = (seen >= {1'b0, drive_q.dac_code});
  end
endmodule

// ---- testbench/sar_adc_conversion_control_tb.sv ----
`timescale 1ns/1ns
module sar_adc_conversion_control_tb;
  import adc_ctrl_pkg::*;
  logic          sys_clk;
  logic          reset_n;
  adc_cfg_t      cfg;
  logic          result_low_write;
  logic          irq_clear;
  code_t         result_data_q;
  logic [3:0]    result_channel_q;
  logic          busy_q;
  logic          irq_q;
  logic [14:0]   digital_in_q;
  logic          ext_start;
  logic          cmp_in;
  logic [14:0]   analog_pins;
  analog_drive_t drive_q;
  code_t         level;
  logic          offset_on;
  int            miscompares;
  int            n_checks;
  int            seed;
  int            m;
  logic [3:0]    ch;
  code_t         v;

  sar_adc_conversion_control sar_adc_conversion_control_inst (.sys_clk(sys_clk),
    .reset_n(reset_n), .cfg(cfg), .result_low_write(result_low_write),
    .irq_clear(irq_clear), .result_data_q(result_data_q),
    .result_channel_q(result_channel_q), .busy_q(busy_q), .irq_q(irq_q),
    .digital_in_q(digital_in_q), .ext_start(ext_start), .cmp_in(cmp_in),
    .analog_pins(analog_pins), .drive_q(drive_q));
  adc_front_model adc_front_model_inst (.sys_clk(sys_clk), .drive_q(drive_q),
    .level(level), .offset_on(offset_on), .cmp_in(cmp_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic int smp_div(input logic [1:0] p);
    return (p == 0) ? 10 : (p == 1) ? 20 : (p == 2) ? 40 : 60;
  endfunction

  function automatic int conv_div(input logic [1:0] p);
    return 5 << p;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic start_conv(input logic [1:0] p, input logic cont, input code_t lv);
    @(negedge sys_clk);
    cfg = '{continuous: cont, ext_trig_en: 1'b0, prescaler: p, channel: ch};
    level = lv;
    result_low_write = 1'b1;
    @(negedge sys_clk);
    result_low_write = 1'b0;
  endtask

  task automatic measure(input logic [1:0] p, input code_t exp_v, input int pre = 0);
    int s;
    int c;
    for (s = 0; s < 8 && drive_q.sample !== 1'b1; s++) @(negedge sys_clk);
    check("sample on", drive_q.sample, 1);
    check("mux", drive_q.mux_sel, ch);
    for (s = 0; s < 2000 && drive_q.sample === 1'b1; s++) @(negedge sys_clk);
    check("sample len", s + pre, 4 * smp_div(p));
    for (c = 0; c < 2000 && busy_q === 1'b1; c++) @(negedge sys_clk);
    check("conv len", c, 12 * conv_div(p) + 1);
    // The stored result reaches the read register one cycle after busy falls.
    @(negedge sys_clk);
    check("irq", irq_q, 1);
    check("result", result_data_q, exp_v);
    check("channel", result_channel_q, ch);
  endtask

  task automatic clear_irq;
    @(negedge sys_clk);
    irq_clear = 1'b1;
    @(negedge sys_clk);
    irq_clear = 1'b0;
    check("irq cleared", irq_q, 0);
  endtask

  initial
  begin
    seed = 20236;
    cfg = '0;
    result_low_write = 1'b0;
    irq_clear = 1'b0;
    ext_start = 1'b0;
    analog_pins = 15'h0000;
    level = 10'h000;
    offset_on = 1'b0;
    ch = 4'h0;
    reset_n = 1'b0;
    miscompares = 0;
    n_checks = 0;
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    for (m = 0; m < 8; m++)
    begin
      ch = 4'({$random(seed)} % 15);
      v = (m == 4) ? 10'h000 : (m == 5) ? 10'h3fe : 10'({$random(seed)} % 1023);
      offset_on = m[1];
      analog_pins = 15'($random(seed));
      start_conv(2'(m % 4), 1'b0, v);
      measure(2'(m % 4), v);
      check("digital in", digital_in_q, analog_pins);
      clear_irq();
    end
    // A restart in mid-conversion must take the new sample.
    start_conv(2'd0, 1'b0, 10'h064);
    repeat (60) @(negedge sys_clk);
    start_conv(2'd0, 1'b0, 10'h0c8);
    measure(2'd0, 10'h0c8);
    clear_irq();
    start_conv(2'd1, 1'b1, 10'h155);
    measure(2'd1, 10'h155);
    clear_irq();
    // The restarted sample phase began two cycles before this call.
    measure(2'd1, 10'h155, 2);
    cfg.continuous = 1'b0;
    for (m = 0; m < 2000 && busy_q !== 1'b0; m++) @(negedge sys_clk);
    clear_irq();
    cfg.ext_trig_en = 1'b1;
    ext_start = 1'b1;
    measure(2'd1, 10'h155);
    ext_start = 1'b0;
    cfg.ext_trig_en = 1'b0;
    clear_irq();
    ext_start = 1'b1;
    repeat (10) @(negedge sys_clk);
    check("ext masked", busy_q, 0);
    report_and_stop();
  end

  initial
  begin
    #3000000;
    miscompares++;
    report_and_stop();
  end
endmodule
